/* core/fpsh_filter.sv */
// Final FIR section with phase selection, first-order high-pass and output buffer.
`include "fpsh_params.svh"

module fpsh_filter #(
    parameter int N_TAPS     = `FPSH_N_TAPS,
    parameter int DECIM      = `FPSH_DECIM,
    parameter int FIFO_DEPTH = `FPSH_FIFO_DEPTH
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_sync,
    input  wire logic                  i_phase_select_bit,
    input  wire logic [15:0]           i_highpass_corner_word,
    input  wire fpsh_pkg::fpsh_coef_wr_t i_coef_wr,
    input  wire logic                  i_in_valid,
    input  wire fpsh_pkg::fpsh_smp_t   i_in,
    output logic                       o_in_ready,
    output logic                       o_out_valid,
    output fpsh_pkg::fpsh_smp_t        o_out,
    input  wire logic                  i_out_ready,
    output logic                       o_settled
);
    import fpsh_pkg::*;

    localparam int PW = $clog2(N_TAPS);
    localparam int DW = (DECIM > 1) ? $clog2(DECIM) : 1;

    // Tail of the tabulated tap sets; the head is loaded via the coefficient port.
    function automatic logic signed [27:0] tail_tap(input int i, input logic set_min);
        logic signed [27:0] v;
        v = '0;
        case (i)
            98:      v = set_min ? -28'sd349 : 28'sd22008;
            99:      v = set_min ? -28'sd96  : 28'sd10620;
            100:     v = set_min ? 28'sd144  : -28'sd8280;
            101:     v = set_min ? 28'sd78   : -28'sd10663;
            102:     v = set_min ? -28'sd46  : -28'sd266;
            103:     v = set_min ? -28'sd42  : 28'sd7419;
            104:     v = set_min ? 28'sd9    : 28'sd6692;
            105:     v = set_min ? 28'sd16   : 28'sd2481;
            106:     v = set_min ? 28'sd0    : -28'sd75;
            107:     v = set_min ? -28'sd4   : -28'sd432;
            108:     v = set_min ? 28'sd0    : -28'sd132;
            default: v = '0;
        endcase
        return v;
    endfunction

    logic signed [27:0] coef_lin [N_TAPS];
    logic signed [27:0] coef_min [N_TAPS];
    logic signed [23:0] hist     [N_TAPS];

    fpsh_state_t        state;
    fpsh_state_t        next_state;
    logic [PW-1:0]      wp;
    logic [PW-1:0]      rp;
    logic [PW:0]        tap;
    logic [DW-1:0]      dec_cnt;
    logic signed [59:0] acc;
    logic               phase_sel;
    logic [17:0]        gain_q17;
    logic [33:0]        pole_b;
    logic signed [24:0] x_prev;
    logic signed [35:0] y;
    logic signed [23:0] result;
    logic [5:0]         drop;
    logic [PW:0]        mac_cycles;

    logic               f_in_valid;
    logic               f_in_ready;
    logic               f_out_valid;
    logic [23:0]        f_out_data;

    // Input acceptance and decimation decode.
    wire                take     = i_in_valid && o_in_ready && !i_sync;
    wire                last_in  = (dec_cnt == DW'(DECIM - 1));
    wire                mac_done = (tap == (PW+1)'(N_TAPS - 1));
    wire                out_load = !o_out_valid || i_out_ready;

    // Tap product: selected set applied to the history walked backwards.
    wire signed [27:0]  coef_cur = phase_sel ? coef_min[tap[PW-1:0]] : coef_lin[tap[PW-1:0]];
    wire signed [51:0]  prod     = hist[rp] * coef_cur;
    wire [PW-1:0]       rp_dec   = (rp == '0) ? PW'(N_TAPS - 1) : rp - PW'(1);
    wire [PW-1:0]       wp_inc   = (wp == PW'(N_TAPS - 1)) ? '0 : wp + PW'(1);

    // High-pass arithmetic in fixed point; a has 16 fraction bits.
    wire [16:0]         one_m_a  = 17'h10000 - {1'b0, i_highpass_corner_word};
    wire [33:0]         sq_1ma   = one_m_a * one_m_a;
    wire [33:0]         next_b   = 34'((35'h100000000 + {1'b0, sq_1ma}) >> 1);
    // Zero gain (2-a)/2 reaches 1.0 in Q17 at a=0, so it needs an 18th bit.
    wire [17:0]         next_g   = 18'h20000 - {2'b00, i_highpass_corner_word};
    wire signed [24:0]  fir_cur  = 25'(acc >>> `FPSH_FIR_SHIFT);
    wire signed [25:0]  diff     = 26'(fir_cur) - 26'(x_prev);
    wire signed [44:0]  t_zero   = diff * $signed({1'b0, gain_q17});
    wire signed [70:0]  t_pole   = y * $signed({1'b0, pole_b});
    wire signed [35:0]  next_y   = 36'(t_zero >>> (17 - `FPSH_Y_FRAC)) + 36'(t_pole >>> 32);
    wire signed [27:0]  y_int    = 28'(next_y >>> `FPSH_Y_FRAC);
    wire signed [23:0]  y_sat    = (y_int > 28'sh07FFFFF) ? 24'sh7FFFFF :
                                   (y_int < -28'sh0800000) ? -24'sh800000 : 24'(y_int);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = (take && last_in) ? ST_MAC : ST_IDLE;
            ST_MAC:  next_state = mac_done ? ST_HPF : ST_MAC;
            ST_HPF:  next_state = ST_PUSH;
            ST_PUSH: next_state = (f_in_ready || drop != '0) ? ST_IDLE : ST_PUSH;
            default: next_state = ST_IDLE;
        endcase
        if (i_sync)
        begin
            next_state = ST_IDLE;
        end
    end

    assign f_in_valid = (state == ST_PUSH) && (drop == '0);

    // Coefficient store; a load writes either set.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < N_TAPS; i++)
            begin
                coef_lin[i] <= tail_tap(i, 1'b0);
                coef_min[i] <= tail_tap(i, 1'b1);
            end
        end
        else if (i_coef_wr.we && i_coef_wr.idx < 7'(N_TAPS))
        begin
            if (i_coef_wr.set_min)
            begin
                coef_min[i_coef_wr.idx[PW-1:0]] <= i_coef_wr.val;
            end
            else
            begin
                coef_lin[i_coef_wr.idx[PW-1:0]] <= i_coef_wr.val;
            end
        end
    end

    // Sample history; cleared on every restart so both sets settle alike.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || i_sync)
        begin
            for (int i = 0; i < N_TAPS; i++)
            begin
                hist[i] <= '0;
            end
        end
        else if (take)
        begin
            hist[wp] <= i_in.data;
        end
    end

    // Restart latches the phase choice and the high-pass coefficients.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            phase_sel <= 1'b0;
            gain_q17  <= 18'h20000;
            pole_b    <= 34'h100000000;
        end
        else if (i_sync)
        begin
            phase_sel <= i_phase_select_bit;
            gain_q17  <= next_g;
            pole_b    <= next_b;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || i_sync)
        begin
            state   <= ST_IDLE;
            wp      <= '0;
            rp      <= '0;
            tap     <= '0;
            dec_cnt <= '0;
            acc     <= '0;
        end
        else
        begin
            state <= next_state;
            if (take)
            begin
                wp      <= wp_inc;
                dec_cnt <= last_in ? '0 : dec_cnt + DW'(1);
                rp      <= wp;
                tap     <= '0;
                acc     <= '0;
            end
            if (state == ST_MAC)
            begin
                acc <= acc + 60'(prod);
                rp  <= rp_dec;
                tap <= tap + (PW+1)'(1);
            end
        end
    end

    // High-pass state and settling counter.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || i_sync)
        begin
            x_prev <= '0;
            y      <= '0;
            result <= '0;
            drop   <= 6'(`FPSH_DROP_COUNT);
        end
        else
        begin
            if (state == ST_HPF)
            begin
                x_prev <= fir_cur;
                y      <= next_y;
                result <= y_sat;
            end
            if (state == ST_PUSH && drop != '0)
            begin
                drop <= drop - 6'd1;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_in_ready  <= 1'b0;
            o_out_valid <= 1'b0;
            o_out       <= '0;
            o_settled   <= 1'b0;
        end
        else
        begin
            o_in_ready <= (next_state == ST_IDLE) && !i_sync;
            o_settled  <= !i_sync && (drop == '0);
            if (out_load)
            begin
                o_out_valid <= f_out_valid;
                o_out.data  <= f_out_data;
            end
        end
    end

    fpsh_fifo #(
        .W (24),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_in_valid  (f_in_valid),
        .i_in_data   (result),
        .o_in_ready  (f_in_ready),
        .o_out_valid (f_out_valid),
        .o_out_data  (f_out_data),
        .i_out_ready (out_load)
    );

    // Helper count of multiply cycles per output sample.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || state == ST_IDLE)
        begin
            mac_cycles <= '0;
        end
        else if (state == ST_MAC)
        begin
            mac_cycles <= mac_cycles + (PW+1)'(1);
        end
    end

    a_drop_count_load: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        i_sync |=> (drop == 6'd63) ##1 (drop == 6'd63))
        else $error("settling count not reloaded on restart");

    a_drop_blocks_push: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (state == ST_PUSH && drop != '0) |-> !f_in_valid ##1 !f_in_valid)
        else $error("result pushed while still settling");

    a_phase_latch_sync: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        i_sync |=> (phase_sel == $past(i_phase_select_bit)))
        else $error("phase choice not taken at restart");

    a_phase_hold_run: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !i_sync |=> $stable(phase_sel) && $stable(pole_b) && $stable(gain_q17))
        else $error("filter settings changed outside a restart");

    a_pole_zero_corner: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_sync && i_highpass_corner_word == 16'h0000) |=> (pole_b == 34'h100000000))
        else $error("pole not unity for zero corner word");

    a_gain_corner_sum: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        i_sync |=> (18'(gain_q17) + 18'($past(i_highpass_corner_word)) == 18'h20000))
        else $error("zero gain does not track corner word");

    a_mac_tap_count: assert property (
        @(posedge i_core_clk) disable iff (i_rst || i_sync)
        (state == ST_MAC && next_state == ST_HPF) |=> (mac_cycles == (PW+1)'(N_TAPS)))
        else $error("wrong number of taps accumulated");

    a_out_hold_stall: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (o_out_valid && !i_out_ready) |=> o_out_valid && $stable(o_out))
        else $error("output changed while stalled");
endmodule // fpsh_filter

/* common/fpsh_params.svh */
// Constants for the phase-selectable FIR tail and the high-pass stage.
`ifndef FPSH_PARAMS_SVH
`define FPSH_PARAMS_SVH
`define FPSH_N_TAPS      110
`define FPSH_DECIM       2
`define FPSH_FIR_SHIFT   27
`define FPSH_DROP_COUNT  63
`define FPSH_FIFO_DEPTH  8
`define FPSH_A_FRAC      16
`define FPSH_Y_FRAC      8
`endif

/* common/fpsh_pkg.sv */
// Types shared by the filter tail, the far-side model and the bench.
package fpsh_pkg;
    typedef struct packed {
        logic signed [23:0] data;
    } fpsh_smp_t;

    typedef struct packed {
        logic               we;
        logic               set_min;
        logic [6:0]         idx;
        logic signed [27:0] val;
    } fpsh_coef_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MAC  = 2'b01,
        ST_HPF  = 2'b10,
        ST_PUSH = 2'b11
    } fpsh_state_t;
endpackage

/* core/fpsh_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
module fpsh_fifo #(
    parameter int W = 24,
    parameter int D = 8
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   count;

    wire push = i_in_valid && o_in_ready;
    wire pop  = o_out_valid && i_out_ready;

    assign o_in_ready  = (count != (AW+1)'(D));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rp];

    always_ff @(posedge i_core_clk)
    begin
        if (push)
        begin
            mem[wp] <= i_in_data;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            wp    <= '0;
            rp    <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wp <= (wp == AW'(D - 1)) ? '0 : wp + AW'(1);
            end
            if (pop)
            begin
                rp <= (rp == AW'(D - 1)) ? '0 : rp + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // fpsh_fifo

/* verif/fpsh_far_side.sv */
// Far-side model: upstream sample source and downstream result sink.
module fpsh_far_side
    import fpsh_pkg::*;
(
    input  wire logic           i_core_clk,
    input  wire logic           i_in_ready,
    input  wire logic [1:0]     i_sink_mode,
    output logic                o_in_valid,
    output fpsh_pkg::fpsh_smp_t o_in,
    output logic                o_out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;

    initial
    begin
        o_in_valid = 1'h0;
        o_in = '0;
        o_out_ready = 1'h0;
    end

    // Holds a sample until an edge sees ready; the caller releases the line.
    task automatic send(input logic signed [23:0] x);
        o_in_valid <= 1'h1;
        o_in.data <= x;
        do
        begin
            @(negedge i_core_clk);
            acc = i_in_ready;
            @(posedge i_core_clk);
        end
        while (acc !== 1'h1);
    endtask

    // Released data shows the inverse of the last word so stale data never passes.
    task automatic idle();
        o_in_valid <= 1'h0;
        o_in.data <= ~o_in.data;
    endtask

    // Mode 0 always accepts, mode 1 stalls at random, mode 2 stalls throughout.
    always @(posedge i_core_clk)
        o_out_ready <= (i_sink_mode == 2'h0) || (i_sink_mode == 2'h1 && $urandom_range(1, 0) == 1);
endmodule // fpsh_far_side

/* verif/fpsh_filter_test.sv */
// Self-checking bench for the filter tail: drop count, phase sets, high-pass and buffering.
module fpsh_filter_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fpsh_pkg::*;
    typedef struct {logic signed [23:0] val; int tol;} fpsh_exp_t;
    localparam longint LIN [11] = '{22008, 10620, -8280, -10663, -266, 7419, 6692, 2481, -75, -432, -132};
    localparam longint MIN [11] = '{-349, -96, 144, 78, -46, -42, 9, 16, 0, -4, 0};
    logic          clk, rst, sync, phase_select_bit, in_valid, in_ready, out_valid, out_ready, settled;
    logic [15:0]   corner;
    logic [1:0]    sink_mode;
    fpsh_coef_wr_t coef_wr;
    fpsh_smp_t     in_smp, out_smp;
    longint        coef [2][110];
    longint        hist [110];
    fpsh_exp_t     expq [$];
    int            n_fail = 0, num_checks = 0, n_in = 0, cyc = 0;
    logic          set_q;

    fpsh_filter #(.N_TAPS(110), .DECIM(2), .FIFO_DEPTH(8)) uut (.i_core_clk(clk), .i_rst(rst), .i_sync(sync),
        .i_phase_select_bit(phase_select_bit), .i_highpass_corner_word(corner), .i_coef_wr(coef_wr), .i_in_valid(in_valid),
        .i_in(in_smp), .o_in_ready(in_ready), .o_out_valid(out_valid), .o_out(out_smp), .i_out_ready(out_ready),
        .o_settled(settled));
    fpsh_far_side u_far (.i_core_clk(clk), .i_in_ready(in_ready), .i_sink_mode(sink_mode), .o_in_valid(in_valid),
        .o_in(in_smp), .o_out_ready(out_ready));

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic summarize();
        if (expq.size() != 0)
        begin
            n_fail++;
            $display("unexpected missing samples at %0t: got %h expected %h", $time, 0, expq.size());
        end
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_smp(input logic signed [23:0] got, input fpsh_exp_t e);
        num_checks++;
        if ($isunknown(got) || (e.tol == 0 ? got !== e.val : (got > e.val + e.tol || got < e.val - e.tol)))
        begin
            n_fail++;
            $display("unexpected sample at %0t: got %h expected %h", $time, got, e.val);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic load(input logic set, input logic [6:0] idx, input logic signed [27:0] v);
        coef_wr <= '{we: 1'h1, set_min: set, idx: idx, val: v};
        @(posedge clk);
        coef_wr <= '0;
        @(posedge clk);
        if (idx < 110)
            coef[set][idx] = v;
    endtask

    task automatic restart(input logic set, input logic [15:0] a);
        sync <= 1'h1;
        phase_select_bit <= set;
        corner <= a;
        @(posedge clk);
        sync <= 1'h0;
        set_q = set;
        n_in = 0;
        hist = '{default: 0};
    endtask

    // Reference output: tap sum over the history, truncated by 27 bits and saturated.
    task automatic feed(input logic signed [23:0] x, input int tol);
        longint acc;
        fpsh_exp_t e;
        phase_select_bit <= 1'($urandom);
        corner <= 16'($urandom);
        u_far.send(x);
        n_in++;
        for (int k = 109; k > 0; k--)
            hist[k] = hist[k - 1];
        hist[0] = x;
        if (n_in == 126)
            check_bit(settled, 1'h0);
        if (n_in == 128)
            check_bit(settled, 1'h1);
        if (n_in % 2 == 0 && n_in > 126)
        begin
            acc = 0;
            for (int k = 0; k < 110; k++)
                acc += coef[set_q][k] * hist[k];
            acc = acc >>> 27;
            e.val = acc > 8388607 ? 24'h7FFFFF : acc < -8388608 ? 24'h800000 : 24'(acc);
            // A settled high-pass leaves nothing of a constant input.
            if (tol > 0)
                e.val = 24'h000000;
            e.tol = (tol > 0 && n_in < 150) ? -1 : tol;
            expq.push_back(e);
        end
    endtask

    task automatic drain();
        u_far.idle();
        for (int i = 0; i < 4000 && expq.size() > 0; i++)
            @(posedge clk);
    endtask

    always @(negedge clk)
        if (!rst && out_valid === 1'h1 && out_ready === 1'h1)
        begin
            if (expq.size() == 0)
            begin
                n_fail++;
                $display("unexpected extra sample at %0t: got %h expected %h", $time, out_smp.data, 24'h0);
            end
            else if (expq[0].tol < 0)
                void'(expq.pop_front());
            else
                check_smp(out_smp.data, expq.pop_front());
        end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(32'hA8F6A307));
        rst = 1'h1;
        sync = 1'h0;
        phase_select_bit = 1'h0;
        corner = 16'h0000;
        coef_wr = '0;
        sink_mode = 2'h0;
        for (int s = 0; s < 2; s++)
            for (int k = 0; k < 110; k++)
                coef[s][k] = (k >= 98 && k <= 108) ? (s ? MIN[k - 98] : LIN[k - 98]) : 0;
        repeat (16) @(posedge clk);
        check_bit(in_ready, 1'h0);
        check_bit(out_valid, 1'h0);
        check_bit(settled, 1'h0);
        rst <= 1'h0;
        @(posedge clk);
        load(1'h0, 7'h00, 28'(int'($urandom) >>> 6));
        load(1'h1, 7'h01, 28'(int'($urandom) >>> 6));
        load(1'h1, 7'h7F, 28'h0FFFFFF);
        // Linear set, corner word zero gives an identity high-pass.
        restart(1'h0, 16'h0000);
        sink_mode <= 2'h1;
        repeat (160) feed(24'(int'($urandom) >>> 9), 0);
        drain();
        // Minimum set with the sink stalled long enough to fill the buffer.
        restart(1'h1, 16'h0000);
        sink_mode <= 2'h2;
        fork
            begin
                repeat (9000) @(posedge clk);
                sink_mode <= 2'h1;
            end
        join_none
        repeat (160) feed(24'(int'($urandom) >>> 9), 0);
        drain();
        // Constant input must be blocked once the high-pass has settled.
        restart(1'h0, 16'h8000);
        repeat (170) feed(24'h400000, 4);
        drain();
        // Example corner words; a restart must clear the settled status again.
        restart(1'h0, 16'h0337);
        restart(1'h1, 16'h019A);
        @(posedge clk);
        check_bit(settled, 1'h0);
        summarize();
    end
endmodule // fpsh_filter_test
